/* File: ddr_port_pkg.sv */
/*
 * Shared constants and carrier types for the two-word-burst DDR SRAM port.
 * Assumes one system clock that oversamples every pin of the link.
 */
package ddr_port_pkg;
    localparam int DATA_W = 36;
    localparam int LANE_W = 9;
    localparam int LANES = DATA_W / LANE_W;
    localparam int ADDR_W = 10;
    localparam int FIFO_DEPTH = 8;
    localparam int SYNC_STAGES = 3;
    localparam int READ_LATENCY_EDGES = 1;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [LANES-1:0] lane_n;
    } write_word_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [LANES-1:0] lane_n;
    } store_req_s;
endpackage

/* File: ddr_word_fifo.sv */
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes both sides run on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
module ddr_word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // Drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [PW:0] cnt_q;
    logic push;
    logic pop;

    assign o_in_ready = (cnt_q != PW'(0) + (PW+1)'(DEPTH));
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data = mem[rd_q];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_ff @(posedge i_clock) begin
        if (push) begin
            mem[wr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + PW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + PW'(1);
            end
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

/* File: ddr_burst2_sram_port.sv */
/*
 * Device side of a common-I/O DDR SRAM with two-word bursts: samples the
 * link pins, stores writes into an internal array, returns reads.
 * Assumes i_clock is much faster than the link clocks, which arrive as pins.
 */
// What this block does
// - Address is registered on the rising edge of the input clock.
// - Every write, and every read issued while no other read is in progress, moves exactly two data words.
// - burst_start_bit is the lowest address bit; bursts start at either word.
// - load_strobe_n high means no operation; address is ignored.
// - read_write_n high reads, low writes, sampled with the load strobe.
// - Write data captured on input clock and complementary clock rises.
// - Only lanes with byte_write_n low are stored.
// - Each of the two write words has its own byte mask.
// - 18-bit uses 18 lines and two enables; 36-bit uses 36 and four.
// - Read data follows output clocks, or input clocks when outputs held high.
// - First read word on complementary output clock rise, second on true.
// - Echo strobes run continuously, aligned to read data, stop with clocks.
`timescale 1ns/100ps
`default_nettype none
module ddr_burst2_sram_port #(
    parameter int DATA_W = ddr_port_pkg::DATA_W,
    parameter int ADDR_W = ddr_port_pkg::ADDR_W
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Input clock pair and controls
    input wire logic i_in_clk,
    input wire logic i_in_clk_n,
    input wire logic i_load_strobe_n,
    input wire logic i_read_write_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W/9-1:0] i_byte_write_n,
    // Output clock pair
    input wire logic i_out_clk,
    input wire logic i_out_clk_n,
    // Data lines
    input wire logic [DATA_W-1:0] i_data_io,
    output logic [DATA_W-1:0] o_data_io,
    output logic o_data_io_oe,
    // Echo strobes
    output logic o_echo_strobe,
    output logic o_echo_strobe_n
);
    localparam int LANES = DATA_W / ddr_port_pkg::LANE_W;
    localparam int LW = ddr_port_pkg::LANE_W;
    localparam int N = ddr_port_pkg::SYNC_STAGES;
    localparam int WORDS = 2 ** ADDR_W;

    typedef enum logic [1:0] {RD_IDLE, RD_FIRST, RD_SECOND} read_state_e;

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    localparam int SW = 4 + 1 + 1 + ADDR_W + LANES + DATA_W;
    logic [SW-1:0] pins;
    logic [SW-1:0] s1_q;
    logic [SW-1:0] s2_q;
    logic [SW-1:0] s3_q;
    assign pins = {i_in_clk, i_in_clk_n, i_out_clk, i_out_clk_n, i_load_strobe_n,
                   i_read_write_n, i_addr, i_byte_write_n, i_data_io};

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Stable view: changes once second and third stages agree
    logic [SW-1:0] st_q;
    logic [SW-1:0] st_d;
    always_comb begin
        for (int b = 0; b < SW; b++) begin
            st_d[b] = (s2_q[b] == s3_q[b]) ? s3_q[b] : st_q[b];
        end
    end
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    logic k_d, kn_d, c_d, cn_d, ld_n, rw_n;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] bw_n;
    logic [DATA_W-1:0] din;
    assign {k_d, kn_d, c_d, cn_d} = st_d[SW-1 -: 4];
    assign ld_n = st_q[SW-5];
    assign rw_n = st_q[SW-6];
    assign addr = st_q[SW-7 -: ADDR_W];
    assign bw_n = st_q[DATA_W +: LANES];
    assign din = st_q[DATA_W-1:0];

    // Edges count only once the stable view has left its reset value,
    // else idle-high pins would look like rises just after reset
    logic [2:0] warm_q;
    logic live;
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            warm_q <= '0;
        end else if (!live) begin
            warm_q <= warm_q + 3'h1;
        end
    end
    assign live = (warm_q == 3'(N + 1));

    // Rising edges of the four link clocks
    logic k_rise, kn_rise, c_rise, cn_rise;
    assign k_rise = live && k_d && !st_q[SW-1];
    assign kn_rise = live && kn_d && !st_q[SW-2];
    assign c_rise = live && c_d && !st_q[SW-3];
    assign cn_rise = live && cn_d && !st_q[SW-4];

    // ---------------------------------------------------------------
    // Command capture
    // ---------------------------------------------------------------
    logic wr_pend_q;
    logic rd_go;
    logic [ADDR_W-1:0] base_q;
    ddr_port_pkg::write_word_s first_q;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_pend_q <= 1'b0;
            base_q <= '0;
            first_q <= '0;
        end else if (k_rise) begin
            if (!ld_n) begin
                base_q <= addr;
            end
            wr_pend_q <= !ld_n && !rw_n;
            first_q <= '{data: din, lane_n: bw_n};
        end else if (kn_rise) begin
            wr_pend_q <= 1'b0;
        end
    end
    assign rd_go = k_rise && !ld_n && rw_n;

    // ---------------------------------------------------------------
    // Write path through FIFO
    // ---------------------------------------------------------------
    // two words, pair partner by lowest bit flip
    ddr_port_pkg::store_req_s push_word;
    logic push_valid;
    logic push_hold_q;
    ddr_port_pkg::store_req_s pend_q;
    logic fifo_ready;
    ddr_port_pkg::store_req_s store_word;
    logic store_valid;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            push_hold_q <= 1'b0;
            pend_q <= '0;
        end else if (wr_pend_q && kn_rise) begin
            // second word on the complementary clock
            push_hold_q <= 1'b1;
            pend_q <= '{addr: base_q ^ ADDR_W'(1), data: din, lane_n: bw_n};
        end else if (push_hold_q && fifo_ready) begin
            push_hold_q <= 1'b0;
        end
    end

    assign push_valid = (wr_pend_q && kn_rise) || push_hold_q;
    always_comb begin
        if (push_hold_q) begin
            push_word = pend_q;
        end else begin
            push_word = '{addr: base_q, data: first_q.data, lane_n: first_q.lane_n};
        end
    end

    // Second word queued behind first; simple eight-entry ordering via FIFO
    ddr_word_fifo #(
        .WIDTH($bits(ddr_port_pkg::store_req_s)),
        .DEPTH(ddr_port_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_in_valid(push_valid),
        .o_in_ready(fifo_ready),
        .i_in_data(push_word),
        .o_out_valid(store_valid),
        .i_out_ready(1'b1),
        .o_out_data(store_word)
    );

    // ---------------------------------------------------------------
    // Storage array
    // ---------------------------------------------------------------
    logic [DATA_W-1:0] mem [WORDS];
    always_ff @(posedge i_clock) begin
        if (store_valid) begin
            for (int l = 0; l < LANES; l++) begin
                if (!store_word.lane_n[l]) begin
                    mem[store_word.addr][l*LW +: LW] <= store_word.data[l*LW +: LW];
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Read path
    // ---------------------------------------------------------------
    read_state_e rd_q;
    logic [ADDR_W-1:0] rd_addr_q;
    logic use_k;
    logic first_edge;
    logic second_edge;
    // output clocks held high select input clocks
    assign use_k = c_d && cn_d;
    assign first_edge = use_k ? kn_rise : cn_rise;
    assign second_edge = use_k ? k_rise : c_rise;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rd_q <= RD_IDLE;
            rd_addr_q <= '0;
            o_data_io <= '0;
            o_data_io_oe <= 1'b0;
        end else begin
            case (rd_q)
                RD_IDLE: begin
                    if (rd_go) begin
                        rd_q <= RD_FIRST;
                        rd_addr_q <= addr;
                    end
                    // bus released one link period after the first word
                    if (first_edge) begin
                        o_data_io_oe <= 1'b0;
                    end
                end
                RD_FIRST: begin
                    if (first_edge) begin
                        o_data_io <= mem[rd_addr_q];
                        o_data_io_oe <= 1'b1;
                        rd_q <= RD_SECOND;
                    end
                end
                RD_SECOND: begin
                    if (second_edge) begin
                        o_data_io <= mem[rd_addr_q ^ ADDR_W'(1)];
                        rd_q <= RD_IDLE;
                    end
                end
                default: rd_q <= RD_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Echo strobes
    // ---------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_echo_strobe <= 1'b0;
            o_echo_strobe_n <= 1'b1;
        end else begin
            o_echo_strobe <= use_k ? k_d : c_d;
            o_echo_strobe_n <= use_k ? kn_d : cn_d;
        end
    end
endmodule
`default_nettype wire

/* File: ddr_port_props.sv */
/* Checker for the DDR burst port pins.
   Assumes link clocks far slower than i_clock. */
`timescale 1ns/100ps
`default_nettype none
module ddr_port_props #(
    parameter int DATA_W = 36
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Link inputs
    input wire logic i_in_clk,
    input wire logic i_in_clk_n,
    input wire logic i_load_strobe_n,
    input wire logic i_read_write_n,
    input wire logic i_out_clk,
    input wire logic i_out_clk_n,
    // Outputs
    input wire logic [DATA_W-1:0] o_data_io,
    input wire logic o_data_io_oe,
    input wire logic o_echo_strobe,
    input wire logic o_echo_strobe_n
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    // ----------------
    // Helper ages
    // ----------------
    logic [3:0] clk_q;
    logic [7:0] rd_age_q;
    logic [3:0] ref_age_q;
    always_ff @(posedge i_clock) begin
        clk_q <= {i_in_clk, i_in_clk_n, i_out_clk, i_out_clk_n};
    end
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) rd_age_q <= 8'hff;
        else if (i_in_clk && !clk_q[3] && !i_load_strobe_n && i_read_write_n) rd_age_q <= 8'h0;
        else if (rd_age_q != 8'hff) rd_age_q <= rd_age_q + 8'h1;
    end
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) ref_age_q <= 4'hf;
        else if (|({i_in_clk, i_in_clk_n, i_out_clk, i_out_clk_n} & ~clk_q)) ref_age_q <= 4'h0;
        else if (ref_age_q != 4'hf) ref_age_q <= ref_age_q + 4'h1;
    end
    sequence s_out_rise;
        $rose(i_out_clk) && !i_out_clk_n;
    endsequence
    sequence s_oe_start;
        $rose(o_data_io_oe);
    endsequence
    property p_echo_out; s_out_rise |-> ##[1:8] $rose(o_echo_strobe); endproperty
    a_echo_out: assert property (p_echo_out) else $error("echo missed out clock rise");
    property p_echo_n; $rose(i_out_clk_n) && !i_out_clk |-> ##[1:8] $rose(o_echo_strobe_n);
    endproperty
    a_echo_n: assert property (p_echo_n) else $error("echo_n missed rise");
    property p_echo_fall; $fell(i_out_clk) && i_out_clk_n |-> ##[1:8] $fell(o_echo_strobe);
    endproperty
    a_echo_fall: assert property (p_echo_fall) else $error("echo missed fall");
    property p_echo_in;
        $rose(i_in_clk) && i_out_clk && i_out_clk_n |-> ##[1:8] $rose(o_echo_strobe);
    endproperty
    a_echo_in: assert property (p_echo_in) else $error("echo ignores input clock");
    property p_rd_only; s_oe_start |-> rd_age_q < 8'd60; endproperty
    a_rd_only: assert property (p_rd_only) else $error("drive without read");
    property p_oe_hold; s_oe_start |-> o_data_io_oe [*8]; endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("burst cut short");
    property p_oe_drop; s_oe_start |-> ##[8:60] !o_data_io_oe; endproperty
    a_oe_drop: assert property (p_oe_drop) else $error("bus held too long");
    property p_ref_align;
        o_data_io_oe && $past(o_data_io_oe) && $changed(o_data_io) |-> ref_age_q <= 4'd8;
    endproperty
    a_ref_align: assert property (p_ref_align) else $error("data off its clock");
endmodule
`default_nettype wire

/* File: ddr_ctrl_model.sv */
/* Controller model: makes the link clocks and issues bursts.
   Assumes the bench resolves the shared data lines. */
`timescale 1ns/100ps
`default_nettype none
module ddr_ctrl_model (
    // System clock
    input wire logic i_clock,
    // Link pins
    output logic o_in_clk,
    output logic o_out_clk,
    output logic o_out_clk_n,
    output logic o_load_strobe_n,
    output logic o_read_write_n,
    output logic [9:0] o_addr,
    output logic [3:0] o_byte_write_n,
    output logic [35:0] o_data,
    input wire logic [35:0] i_data_io
);
    logic hold_out = 1'b0;
    // complementary pairs, outputs held high on request
    assign o_out_clk = hold_out | o_in_clk;
    assign o_out_clk_n = hold_out | ~o_in_clk;
    initial begin
        {o_in_clk, o_read_write_n, o_addr, o_data} = '0;
        {o_load_strobe_n, o_byte_write_n} = 5'h1f;
        forever begin
            repeat (10) @(negedge i_clock);
            o_in_clk = ~o_in_clk;
        end
    end
    task automatic burst(input logic nop, rd, input logic [9:0] a, input logic [35:0] d0, d1,
        input logic [3:0] m0, m1, output logic [35:0] q0, q1);
        @(negedge o_in_clk);
        // command and first word set up half a period early
        {o_load_strobe_n, o_read_write_n, o_addr, o_data, o_byte_write_n} = {nop, rd, a, d0, m0};
        @(posedge o_in_clk);
        #40;
        // scrambled idle address, second word and mask
        {o_load_strobe_n, o_addr, o_data, o_byte_write_n} = {1'b1, ~a, d1, m1};
        @(negedge o_in_clk);
        #40;
        o_data = ~d1;
        o_byte_write_n = 4'hf;
        #30 q0 = i_data_io;
        #80 q1 = i_data_io;
    endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
/* Bench for the DDR burst port.
   Assumes the controller model in ddr_ctrl_model. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic i_clock, i_rst_b, in_clk, out_clk, out_clk_n, load_n, rw_n, oe, echo, echo_n;
    logic [9:0] addr;
    logic [3:0] bw_n;
    logic [35:0] m_data, d_out, bus, q0, q1, kept;
    int bad_count = 0;
    int checks_done = 0;
    assign bus = oe ? d_out : m_data;
    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end
    ddr_ctrl_model ddr_ctrl_model_inst (.i_clock(i_clock), .o_in_clk(in_clk),
        .o_out_clk(out_clk), .o_out_clk_n(out_clk_n), .o_load_strobe_n(load_n),
        .o_read_write_n(rw_n), .o_addr(addr), .o_byte_write_n(bw_n), .o_data(m_data),
        .i_data_io(bus));
    ddr_burst2_sram_port ddr_burst2_sram_port_inst (.i_clock(i_clock), .i_rst_b(i_rst_b),
        .i_in_clk(in_clk), .i_in_clk_n(~in_clk), .i_load_strobe_n(load_n),
        .i_read_write_n(rw_n), .i_addr(addr), .i_byte_write_n(bw_n), .i_out_clk(out_clk),
        .i_out_clk_n(out_clk_n), .i_data_io(bus), .o_data_io(d_out), .o_data_io_oe(oe),
        .o_echo_strobe(echo), .o_echo_strobe_n(echo_n));
    task automatic chk(input logic [35:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic go(input logic nop, rd, input logic [9:0] a, input logic [35:0] d0, d1,
        input logic [3:0] m0, m1);
        ddr_ctrl_model_inst.burst(nop, rd, a, d0, d1, m0, m1, q0, q1);
    endtask
    task automatic rd2(input logic [9:0] a, input logic [35:0] e0, e1);
        go(1'b0, 1'b1, a, 36'h0, 36'h0, 4'hf, 4'hf);
        chk(q0, e0);
        chk(q1, e1);
    endtask
    function automatic logic [35:0] merge(input logic [35:0] o, n, input logic [3:0] m);
        for (int i = 0; i < 4; i++) if (!m[i]) o[9*i+:9] = n[9*i+:9];
        return o;
    endfunction
    task automatic t_basic;
        go(1'b0, 1'b0, 10'h010, 36'h123456789, 36'h9abcdef01, 4'h0, 4'h0);
        rd2(10'h010, 36'h123456789, 36'h9abcdef01);
        rd2(10'h011, 36'h9abcdef01, 36'h123456789);
        go(1'b0, 1'b0, 10'h3ff, 36'hfedcba987, 36'h0f0f0f0f0, 4'h0, 4'h0);
        rd2(10'h3fe, 36'h0f0f0f0f0, 36'hfedcba987);
    endtask
    task automatic t_mask;
        go(1'b0, 1'b0, 10'h020, 36'h111111111, 36'h222222222, 4'h0, 4'h0);
        go(1'b0, 1'b0, 10'h020, 36'haaaaaaaaa, 36'h555555555, 4'h5, 4'ha);
        kept = merge(36'h111111111, 36'haaaaaaaaa, 4'h5);
        rd2(10'h020, kept, merge(36'h222222222, 36'h555555555, 4'ha));
    endtask
    task automatic t_nop;
        go(1'b1, 1'b0, 10'h020, 36'h0, 36'h0, 4'h0, 4'h0);
        rd2(10'h020, kept, merge(36'h222222222, 36'h555555555, 4'ha));
    endtask
    task automatic t_hold;
        @(negedge in_clk);
        ddr_ctrl_model_inst.hold_out = 1'b1;
        rd2(10'h010, 36'h123456789, 36'h9abcdef01);
        @(negedge in_clk);
        ddr_ctrl_model_inst.hold_out = 1'b0;
        rd2(10'h011, 36'h9abcdef01, 36'h123456789);
    endtask
    task automatic summarize;
        $display("checks %0d bad %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        i_rst_b = 1'b0;
        repeat (16) @(negedge i_clock);
        chk({34'h0, oe, echo_n}, 36'h1);
        i_rst_b = 1'b1;
        t_basic;
        t_mask;
        t_nop;
        t_hold;
        summarize;
    end
    initial begin
        #100000;
        bad_count++;
        $display("BAD %0t timeout", $time);
        summarize;
    end
endmodule
bind ddr_burst2_sram_port ddr_port_props #(.DATA_W(DATA_W)) ddr_port_props_inst (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_in_clk(i_in_clk), .i_in_clk_n(i_in_clk_n),
    .i_load_strobe_n(i_load_strobe_n), .i_read_write_n(i_read_write_n),
    .i_out_clk(i_out_clk), .i_out_clk_n(i_out_clk_n), .o_data_io(o_data_io),
    .o_data_io_oe(o_data_io_oe), .o_echo_strobe(o_echo_strobe),
    .o_echo_strobe_n(o_echo_strobe_n));
`default_nettype wire
